// >>> shared/bra_pkg.sv
package bra_pkg;
    // opcodes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_STATUS_RD = 8'h05;
    localparam logic [7:0] OP_BOOT_RD   = 8'h14;
    localparam logic [7:0] OP_BOOT_WR   = 8'h15;
    // boot register layout
    localparam int REG_W        = 32;
    localparam int BOOT_EN_BIT  = 0;
    localparam int DLY_LSB      = 1;
    localparam int DLY_W        = 4;
    localparam int ADDR_LSB     = 8;
    localparam int ADDR_W       = 24;
    // status byte layout
    localparam int STAT_WIP     = 0;
    localparam int STAT_WEL     = 1;
    localparam int STAT_QE      = 6;
    // bit counts
    localparam logic [5:0] OP_BITS   = 6'h08;
    localparam logic [5:0] DATA_BITS = 6'h20;
    // timing
    localparam int CLK_MHZ      = 20;
    localparam int UPDATE_NS    = 2000;
    localparam int UPDATE_CYC   = (UPDATE_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        ST_CMD   = 3'b000,
        ST_RD    = 3'b001,
        ST_WR    = 3'b010,
        ST_STAT  = 3'b011,
        ST_LATCH = 3'b100,
        ST_BOOT  = 3'b101,
        ST_SKIP  = 3'b110
    } bra_state_t;
endpackage

// >>> rtl/bra_boot_reg.sv
`timescale 1ns/1ps
module bra_boot_reg
    import bra_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // serial link pins
    input  wire logic              cs_n_i,
    input  wire logic              sck_i,
    input  wire logic [3:0]        io_i,
    output logic      [3:0]        io_o,
    output logic      [3:0]        io_oe_o,
    // mode and status
    input  wire logic              four_line_command_mode_i,
    input  wire logic              quad_enable_bit_i,
    output logic                   write_in_progress_flag_o,
    output logic                   write_latch_flag_o,
    // boot code memory
    output logic      [ADDR_W-1:0] boot_addr_o,
    input  wire logic [7:0]        mem_data_i,
    // nonvolatile storage
    input  wire logic [REG_W-1:0]  nv_data_i,
    output logic      [REG_W-1:0]  nv_data_o,
    output logic                   nv_we_o
);
    logic [2:0]       sck_s;
    logic [2:0]       cs_s;
    logic [3:0]       io_s1;
    logic [3:0]       io_s2;
    logic             sck_rise;
    logic             sck_fall;
    logic             cs_rise;
    logic             cs_fall;
    logic             sel;
    bra_state_t       state;
    logic [5:0]       cnt;
    logic [5:0]       next_cnt;
    logic [5:0]       step;
    logic [7:0]       op_sr;
    logic [7:0]       next_op;
    logic [REG_W-1:0] dsr;
    logic [REG_W-1:0] pend;
    logic [REG_W-1:0] boot_reg;
    logic [4:0]       pos;
    logic [7:0]       stat_byte;
    logic             wr_go;
    logic             latch_go;
    logic             boot_armed;
    logic [DLY_W-1:0] sess_dly;
    logic [DLY_W-1:0] dly_cnt;
    logic             byte_sent;
    logic [15:0]      timer;

    // pins cross in from the host clock domain
    always_ff @(posedge clk_i) begin
        sck_s <= {sck_s[1:0], sck_i};
        cs_s  <= {cs_s[1:0], cs_n_i};
        io_s1 <= io_i;
        io_s2 <= io_s1;
    end

    assign sck_rise  = sck_s[1] & ~sck_s[2];
    assign sck_fall  = ~sck_s[1] & sck_s[2];
    assign cs_rise   = cs_s[1] & ~cs_s[2];
    assign cs_fall   = ~cs_s[1] & cs_s[2];
    assign sel       = ~cs_s[1];
    assign step      = four_line_command_mode_i ? 6'h04 : 6'h01;
    assign next_cnt  = cnt + step;
    assign next_op   = four_line_command_mode_i ? {op_sr[3:0], io_s2} : {op_sr[6:0], io_s2[0]};
    assign stat_byte = {1'b0, quad_enable_bit_i, 4'h0, write_latch_flag_o,
                        write_in_progress_flag_o};

    // link state machine
    always_ff @(posedge clk_i) begin
        wr_go    <= 1'b0;
        latch_go <= 1'b0;
        if (rst_i) begin
            state      <= ST_CMD;
            cnt        <= 6'h00;
            op_sr      <= 8'h00;
            dsr        <= '0;
            pend       <= '0;
            pos        <= 5'h00;
            io_o       <= 4'h0;
            io_oe_o    <= 4'h0;
            dly_cnt    <= '0;
            byte_sent  <= 1'b0;
            // session copy taken here, later writes wait for next reset
            boot_armed  <= nv_data_i[BOOT_EN_BIT];
            sess_dly    <= nv_data_i[DLY_LSB +: DLY_W];
            boot_addr_o <= nv_data_i[ADDR_LSB +: ADDR_W];
        end else if (cs_rise) begin
            if (state == ST_WR && cnt == DATA_BITS && write_latch_flag_o
                    && !write_in_progress_flag_o) begin
                wr_go <= 1'b1;
                pend  <= {dsr[7:0], dsr[15:8], dsr[23:16], dsr[31:24]};
            end
            if (state == ST_LATCH && !write_in_progress_flag_o) begin
                latch_go <= 1'b1;
            end
            // boot is one-shot once a byte has gone out
            if (state == ST_BOOT && byte_sent) begin
                boot_armed <= 1'b0;
            end
            state   <= ST_CMD;
            cnt     <= 6'h00;
            io_oe_o <= 4'h0;
        end else if (cs_fall && state == ST_CMD && boot_armed) begin
            state     <= ST_BOOT;
            dly_cnt   <= '0;
            pos       <= 5'h00;
            byte_sent <= 1'b0;
        end else if (sel && sck_rise) begin
            case (state)
                ST_CMD: begin
                    op_sr <= next_op;
                    cnt   <= next_cnt;
                    pos   <= 5'h00;
                    if (next_cnt == OP_BITS) begin
                        cnt <= 6'h00;
                        if (next_op == OP_BOOT_RD) begin
                            state <= ST_RD;
                        end else if (next_op == OP_BOOT_WR) begin
                            state <= ST_WR;
                        end else if (next_op == OP_STATUS_RD) begin
                            state <= ST_STAT;
                        end else if (next_op == OP_LATCH_SET) begin
                            state <= ST_LATCH;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                end
                ST_WR: begin
                    dsr <= four_line_command_mode_i ? {dsr[27:0], io_s2} : {dsr[30:0], io_s2[0]};
                    // count past 32 marks an overlong write as bad
                    if (cnt <= DATA_BITS) begin
                        cnt <= next_cnt;
                    end
                end
                ST_LATCH: begin
                    state <= ST_SKIP;
                end
                ST_BOOT: begin
                    if (dly_cnt != sess_dly) begin
                        dly_cnt <= dly_cnt + 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (sel && sck_fall) begin
            case (state)
                ST_RD: begin
                    pos <= pos + 5'h01;
                    if (four_line_command_mode_i) begin
                        io_oe_o <= 4'hf;
                        io_o    <= boot_reg[{pos[2:1], ~pos[0], 2'b00} +: 4];
                    end else begin
                        io_oe_o <= 4'h2;
                        io_o    <= {2'b00, boot_reg[{pos[4:3], ~pos[2:0]}], 1'b0};
                    end
                end
                ST_STAT: begin
                    pos <= pos + 5'h01;
                    if (four_line_command_mode_i) begin
                        io_oe_o <= 4'hf;
                        io_o    <= stat_byte[{~pos[0], 2'b00} +: 4];
                    end else begin
                        io_oe_o <= 4'h2;
                        io_o    <= {2'b00, stat_byte[~pos[2:0]], 1'b0};
                    end
                end
                ST_BOOT: begin
                    if (dly_cnt == sess_dly) begin
                        pos <= pos + 5'h01;
                        if (quad_enable_bit_i) begin
                            io_oe_o <= 4'hf;
                            io_o    <= mem_data_i[{~pos[0], 2'b00} +: 4];
                            if (pos[0]) begin
                                boot_addr_o <= boot_addr_o + 1'b1;
                                byte_sent   <= 1'b1;
                            end
                        end else begin
                            io_oe_o <= 4'h2;
                            io_o    <= {2'b00, mem_data_i[~pos[2:0]], 1'b0};
                            if (pos[2:0] == 3'h7) begin
                                boot_addr_o <= boot_addr_o + 1'b1;
                                byte_sent   <= 1'b1;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // update timer, latch and register image
    always_ff @(posedge clk_i) begin
        nv_we_o <= 1'b0;
        if (rst_i) begin
            write_in_progress_flag_o <= 1'b0;
            write_latch_flag_o       <= 1'b0;
            timer                    <= 16'h0000;
            nv_data_o                <= '0;
            // register kept outside, reloaded at each reset
            boot_reg                 <= nv_data_i;
        end else if (write_in_progress_flag_o) begin
            if (timer == 16'h0000) begin
                write_in_progress_flag_o <= 1'b0;
                write_latch_flag_o       <= 1'b0;
                boot_reg                 <= pend;
                nv_data_o                <= pend;
                nv_we_o                  <= 1'b1;
            end else begin
                timer <= timer - 16'h0001;
            end
        end else if (wr_go) begin
            write_in_progress_flag_o <= 1'b1;
            timer                    <= 16'(UPDATE_CYC - 1);
        end else if (latch_go) begin
            write_latch_flag_o <= 1'b1;
        end
    end
endmodule

// >>> bench/bra_boot_reg_properties.sv
`timescale 1ns/1ps
module bra_boot_reg_chk
    import bra_pkg::*;
(
    // watched ports
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              cs_n_i,
    input wire logic [3:0]        io_oe_o,
    input wire logic              write_in_progress_flag_o,
    input wire logic              write_latch_flag_o,
    input wire logic [ADDR_W-1:0] boot_addr_o,
    input wire logic              nv_we_o
);
    localparam int BUSY_LO = UPDATE_CYC - 9;
    localparam int BUSY_HI = UPDATE_CYC - 5;
    wire write_in_progress_flag = write_in_progress_flag_o;
    wire write_latch_flag = write_latch_flag_o;
    logic [7:0] busy_cnt;
    // counts busy cycles so the exact update length can be checked
    always_ff @(posedge clk_i) begin
        if (rst_i || !write_in_progress_flag) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= busy_cnt + 8'h01;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_busy;
        write_in_progress_flag [*8];
    endsequence
    a_busy_needs_latch: assert property ($rose(write_in_progress_flag) |-> write_latch_flag)
        else $error("update started with write latch clear");
    a_busy_length: assert property ($rose(write_in_progress_flag) |-> s_busy ##[BUSY_LO:BUSY_HI] !write_in_progress_flag)
        else $error("progress flag length wrong");
    a_busy_exact: assert property ($fell(write_in_progress_flag) |-> busy_cnt == 8'(UPDATE_CYC))
        else $error("update length not the set cycle count");
    a_latch_cleared: assert property ($fell(write_in_progress_flag) |-> ##[0:1] !write_latch_flag)
        else $error("write latch kept after update");
    a_store_pulse: assert property (nv_we_o |=> !nv_we_o)
        else $error("store strobe longer than one cycle");
    a_store_in_busy: assert property (nv_we_o |-> write_in_progress_flag || $past(write_in_progress_flag))
        else $error("store strobe outside update");
    a_oe_legal: assert property (io_oe_o inside {4'h0, 4'h2, 4'hf})
        else $error("illegal output enable pattern");
    a_idle_released: assert property (cs_n_i [*6] |-> io_oe_o == 4'h0)
        else $error("pins driven while deselected");
    a_addr_steps: assert property (
        $changed(boot_addr_o) |-> boot_addr_o == $past(boot_addr_o) + 1'b1)
        else $error("boot address jumped");
endmodule

// >>> bench/bra_host.sv
`timescale 1ns/1ps
module bra_host (
    // clock and device pins
    input  wire logic       clk_i,
    input  wire logic [3:0] dev_io_i,
    output logic            cs_n_o,
    output logic            sck_o,
    output logic [3:0]      io_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        io_o = 4'h0;
    end
    // low byte first, msb first within byte
    function automatic logic pick(logic [7:0] op, int nop, logic [31:0] wd, int i);
        int d;
        d = i - nop;
        // index wraps so long boot delays never read past the word
        return (i < nop) ? op[7 - i] : wd[5'(8 * (d / 8) + 7 - d % 8)];
    endfunction
    // sample at end of high phase: device output lags the pin fall by a few clocks
    task automatic frame(input logic [7:0] op, input int nop, input logic [31:0] wd,
                         input int nwr, input int nrd, input bit q, output logic [63:0] rd);
        int st;
        int r;
        st = q ? 4 : 1;
        rd = '0;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (int i = 0; i < nop + nwr + nrd; i += st) begin
            if (i >= nop + nwr) io_o = ~io_o;
            for (int k = 0; k < st && i < nop + nwr; k++) begin
                io_o[q ? 3 - k : 0] = pick(op, nop, wd, i + k);
            end
            repeat (4) @(negedge clk_i);
            sck_o = 1'b1;
            repeat (4) @(negedge clk_i);
            for (int k = 0; k < st; k++) begin
                r = i + k - nop - nwr;
                if (r >= 0) rd[8 * (r / 8) + 7 - r % 8] = dev_io_i[q ? 3 - k : 1];
            end
            sck_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        repeat (8) @(negedge clk_i);
    endtask
endmodule

// >>> bench/test_bra_boot_reg.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module test_bra_boot_reg;
    import bra_pkg::*;
    logic              clk_i, rst_i, cs_n, sck, fl, qe, write_in_progress_flag, write_latch_flag, nv_we;
    logic [3:0]        hio, io_i, io_o, io_oe;
    logic [ADDR_W-1:0] baddr;
    logic [REG_W-1:0]  nv_data_i, nv_data_o, v, w, cur;
    logic [63:0]       rd;
    int                n_fail, checks_done, n;
    assign io_i = (io_oe & io_o) | (~io_oe & hio);
    bra_host host (.clk_i(clk_i), .dev_io_i(io_i), .cs_n_o(cs_n), .sck_o(sck), .io_o(hio));
    bra_boot_reg uut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .io_i(io_i),
        .io_o(io_o), .io_oe_o(io_oe), .four_line_command_mode_i(fl), .quad_enable_bit_i(qe),
        .write_in_progress_flag_o(write_in_progress_flag), .write_latch_flag_o(write_latch_flag), .boot_addr_o(baddr),
        .mem_data_i(baddr[7:0] ^ 8'h3c), .nv_data_i(nv_data_i), .nv_data_o(nv_data_o),
        .nv_we_o(nv_we));
    // storage keeps the image across resets
    always @(posedge clk_i) if (nv_we) nv_data_i <= nv_data_o;
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    function automatic logic [7:0] exp_mem(logic [7:0] a);
        return a ^ 8'h3c;
    endfunction
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic pulse_reset();
        rst_i = 1'b1;
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic cmd(logic [7:0] op, logic [31:0] wd, int nwr, int nrd);
        host.frame(op, 8, wd, nwr, nrd, fl, rd);
    endtask
    task automatic stat(logic wp, logic wl);
        cmd(OP_STATUS_RD, 32'h0, 0, 8);
        `CHK(rd[7:0], {1'b0, qe, 4'h0, wl, wp})
    endtask
    initial begin
        rst_i = 1'b1; fl = 1'b0; qe = 1'b0; n_fail = 0; checks_done = 0;
        void'($urandom(26));
        v = $urandom;
        v[7:0] = {3'h0, 4'($urandom_range(1, 15)), 1'b1};
        nv_data_i = v;
        pulse_reset();
        `CHK(baddr, v[31:8])
        host.frame(8'h00, 0, 32'h0, int'(v[DLY_LSB +: DLY_W]), 16, 1'b0, rd);
        `CHK(rd[15:0], {exp_mem(v[15:8] + 8'h1), exp_mem(v[15:8])})
        $display("boot test done");
        cur = v;
        for (int m = 0; m < 2; m++) begin
            fl = m[0];
            qe = 1'($urandom);
            w = (m == 0) ? 32'hffff_ff00 : $urandom;
            // keep boot on with a delay for the quad boot after the last reset
            if (m == 1) w[7:0] = {3'h0, 4'($urandom_range(1, 15)), 1'b1};
            cmd(OP_BOOT_RD, 32'h0, 0, 64);
            `CHK(rd, {cur, cur})
            cmd(OP_BOOT_WR, w, 32, 0);
            `CHK(write_in_progress_flag, 1'b0)
            stat(1'b0, 1'b0);
            cmd(OP_LATCH_SET, 32'h0, 0, 0);
            // four bits move per edge in four-line mode, so the short write is 28 there
            cmd(OP_BOOT_WR, w, fl ? 28 : 31, 0);
            `CHK({write_in_progress_flag, write_latch_flag}, 2'b01)
            cmd(OP_BOOT_RD, 32'h0, 0, 32);
            `CHK(rd[31:0], cur)
            cmd(OP_LATCH_SET, 32'h0, 0, 0);
            cmd(OP_BOOT_WR, w, 32, 0);
            `CHK({write_in_progress_flag, write_latch_flag}, 2'b11)
            n = 0;
            do cmd(OP_STATUS_RD, 32'h0, 0, 8); while (rd[STAT_WIP] !== 1'b0 && ++n < 8);
            if (n == 8) begin n_fail++; wrap_up(); end
            stat(1'b0, 1'b0);
            `CHK(nv_data_o, w)
            cmd(OP_BOOT_RD, 32'h0, 0, 32);
            `CHK(rd[31:0], w)
            cur = w;
            $display("mode %0d done", m);
        end
        // boot ran once for two bytes and was not rearmed by the write
        `CHK(baddr, v[31:8] + 24'h2)
        qe = 1'b1;
        pulse_reset();
        `CHK(baddr, cur[31:8])
        host.frame(8'h00, 0, 32'h0, 4 * int'(cur[DLY_LSB +: DLY_W]), 16, 1'b1, rd);
        `CHK(rd[15:0], {exp_mem(cur[15:8] + 8'h1), exp_mem(cur[15:8])})
        $display("reset test done");
        wrap_up();
    end
endmodule
bind bra_boot_reg bra_boot_reg_chk chk (.*);
